/* File: src/aisr_pkg.sv */
// constants, types and reset table for the analog input scaling and routing block
// Summary of operation
// - each general input is multiplied by its scale setting over 1000, setting 0..1999
// - each analog output multiplies its source value by its scale setting over 1000
// - speed reference input is multiplied by speed scale over 1000 before routing
// - scale spans 0.001 to 1.999; a setting of zero forces zero
// - a new destination setting only takes effect at the next drive reset
// - each general input writes its scaled value to its destination parameter
// - scaled speed reference goes to its destination, default speed reference one
// - speed reference destination may name any readable and writable parameter
// - each analog output takes its value from its source parameter, 0..1999
// - source and destination codes are menu times 100 plus parameter number
// - general inputs are 10-bit bipolar and shown within plus or minus 1000
// - speed reference input is 12-bit bipolar and shown within plus or minus 1000
// - speed reference comes from terminal or encoder; encoder has its own scale
// - line voltage and heatsink temperature are read-only, 0..1000, degrees Celsius
// - speed terminal is voltage or current loop with four milliamp ranges
// - with 4 mA offset range, current below 3.5 mA trips loop open
package aisr_pkg;

   localparam int                 SET_W     = 11;
   localparam int                 VAL_W     = 12;
   localparam int                 SCALE_DIV = 1000;
   localparam logic [10:0]        SET_MAX   = 11'h7CF;
   localparam logic signed [11:0] VAL_LIM   = 12'sh3E8;
   localparam logic [9:0]         MON_LIM   = 10'h3E8;

   // parameter codes of the block (menu 7)
   localparam logic [10:0] IDX_GP_FIRST  = 11'h2BD;
   localparam logic [10:0] IDX_SPEED_IN  = 11'h2C1;
   localparam logic [10:0] IDX_LINE_V    = 11'h2C2;
   localparam logic [10:0] IDX_HEAT_T    = 11'h2C3;
   localparam logic [10:0] IDX_CFG_FIRST = 11'h2C4;
   localparam logic [10:0] IDX_CFG_LAST  = 11'h2D4;
   localparam logic [10:0] IDX_ENC_SEL   = 11'h2D5;
   localparam logic [10:0] IDX_CUR_SEL   = 11'h2D6;
   localparam logic [10:0] IDX_LOOP_INV  = 11'h2D7;
   localparam logic [10:0] IDX_LOOP_OFS  = 11'h2D8;

   // existing parameter space used to qualify routing codes
   localparam int MENU_FIRST = 1;
   localparam int MENU_LAST  = 19;
   localparam int PAR_FIRST  = 1;
   localparam int PAR_LAST   = 50;

   // slots of the setting array
   localparam int NCFG      = 17;
   localparam int CFG_SRC   = 0;
   localparam int CFG_TGT   = 3;
   localparam int CFG_SCL   = 8;
   localparam int CFG_DSCL  = 13;
   localparam int CFG_ENC   = 16;
   localparam int NROUTE    = 5;
   localparam int NDAC      = 3;

   localparam logic [NCFG-1:0][10:0] CFG_RST = {
      11'h1A3,                                   // encoder scale 419
      11'h3E8, 11'h3E8, 11'h3E8,                 // output scales
      11'h3E8, 11'h3E8, 11'h3E8, 11'h3E8, 11'h3E8, // input scales
      11'h075, 11'h198, 11'h078, 11'h077, 11'h13E, // targets
      11'h130, 11'h12E, 11'h0C9};                // sources
   localparam logic CUR_SEL_RST  = 1'b0;
   localparam logic ENC_SEL_RST  = 1'b0;
   localparam logic LOOP_INV_RST = 1'b0;
   localparam logic LOOP_OFS_RST = 1'b1;

   // current loop: full 20 mA is 2048 counts
   localparam int                 RAW_SHIFT_GP  = 9;
   localparam int                 RAW_SHIFT_SPD = 11;
   localparam logic        [11:0] LOOP_4MA      = 12'h19A;
   localparam logic        [11:0] LOOP_3P5MA    = 12'h166;
   localparam logic        [11:0] LOOP_SPAN_MUL = 12'h271;
   localparam int                 LOOP_SPAN_SH  = 10;

   typedef enum logic [3:0] {
      SEQ_IDLE  = 4'b0001,
      SEQ_ROUTE = 4'b0010,
      SEQ_FETCH = 4'b0100,
      SEQ_LOAD  = 4'b1000
   } aisr_seq_e;

   typedef struct packed {
      logic [3:0][9:0] gp_raw;
      logic [11:0]     spd_raw;
      logic [11:0]     enc_rate;
      logic [9:0]      line_raw;
      logic [9:0]      heat_raw;
      logic            drive_reset;
   } aisr_pins_s;

   typedef struct packed {
      logic        [10:0] sel;
      logic               wr;
      logic signed [11:0] wdata;
   } aisr_par_req_s;

   typedef struct packed {
      logic               valid;
      logic        [10:0] index;
      logic signed [11:0] value;
   } aisr_route_s;

endpackage : aisr_pkg

/* File: src/aisr_scale.sv */
// value times setting over 1000, truncated toward zero and saturated
module aisr_scale #(
   parameter logic signed [11:0] LIMIT = aisr_pkg::VAL_LIM
) (
   input  wire logic signed [11:0] value,
   input  wire logic        [10:0] setting,
   output logic signed      [11:0] result
);
   import aisr_pkg::*;

   logic signed [23:0] prod;
   logic signed [23:0] quot;

   if (LIMIT <= 0) begin
      $error("aisr_scale: limit must be positive");
   end

   always_comb begin
      prod = 24'(value) * $signed({13'h0000, setting});
      quot = prod / 24'sd1000;                          // signed division truncates toward zero
      if (quot > 24'(LIMIT))
         result = LIMIT;
      else if (quot < -24'(LIMIT))
         result = -LIMIT;
      else
         result = quot[11:0];
   end

endmodule : aisr_scale

/* File: src/aisr_loop.sv */
// speed terminal conditioning: voltage or one of four current loop ranges
module aisr_loop (
   input  wire logic signed [11:0] raw,
   input  wire logic               cur_sel,
   input  wire logic               loop_inv,
   input  wire logic               loop_ofs,
   output logic signed      [11:0] value,
   output logic                    loop_low
);
   import aisr_pkg::*;

   logic        [11:0] mag;
   logic        [11:0] above;
   logic        [23:0] span;
   logic        [21:0] full;
   logic        [10:0] unipolar;

   always_comb begin
      mag      = raw[11] ? 12'h000 : raw;
      above    = (mag > LOOP_4MA) ? mag - LOOP_4MA : 12'h000;
      span     = {12'h000, above} * {12'h000, LOOP_SPAN_MUL};
      full     = {10'h000, mag} * 22'd1000;
      unipolar = loop_ofs ? 11'(span >> LOOP_SPAN_SH) : 11'(full >> RAW_SHIFT_SPD);
      if (unipolar > 11'(MON_LIM))
         unipolar = 11'(MON_LIM);
      if (!cur_sel)
         value = 12'((22'(raw) * 22'sd1000) >>> RAW_SHIFT_SPD);
      else if (loop_inv)
         value = 12'(MON_LIM) - {1'b0, unipolar};
      else
         value = {1'b0, unipolar};
      loop_low = cur_sel && loop_ofs && (mag < LOOP_3P5MA);
   end

endmodule : aisr_loop

/* File: src/aisr_top.sv */
// analog input scaling, routing, output sourcing and monitors
module aisr_top #(
   parameter int SCAN_DIV = 40
) (
   input  wire logic                     clock,
   input  wire logic                     reset,
   input  wire aisr_pkg::aisr_pins_s     pins,
   input  wire aisr_pkg::aisr_par_req_s  par_req,
   output logic                   [11:0] par_rdata,
   output logic                          par_hit,
   output aisr_pkg::aisr_route_s         route,
   output logic                   [10:0] src_index,
   input  wire logic signed       [11:0] src_value,
   output logic signed  [2:0][11:0]      dac_data,
   output logic                          loop_trip
);
   import aisr_pkg::*;

   typedef struct packed {
      aisr_pins_s                   sy1;
      aisr_pins_s                   sy2;
      logic        [NCFG-1:0][10:0] cfg;
      logic      [NROUTE-1:0][10:0] act_tgt;
      logic                         enc_sel;
      logic                         cur_sel;
      logic                         loop_inv;
      logic                         loop_ofs;
      logic                         drst_old;
      logic                         trip;
      aisr_seq_e                    st;
      logic                   [2:0] ch;
      logic                  [15:0] div;
      logic      [NDAC-1:0][11:0]   dac;
      aisr_route_s                  route;
      logic                  [10:0] src_idx;
      logic                  [11:0] rdata;
      logic                         hit;
   } aisr_state_s;

   if (SCAN_DIV < 1 || SCAN_DIV > 65536) begin
      $error("aisr_top: SCAN_DIV out of range");
   end

   ////////////////////////////////////////////////////////////////////////////////
   // helpers

   function automatic logic param_exists(input logic [10:0] code);
      int menu;
      int par;
      menu = int'(code) / 100;
      par  = int'(code) % 100;
      return menu >= MENU_FIRST && menu <= MENU_LAST && par >= PAR_FIRST && par <= PAR_LAST;
   endfunction : param_exists

   function automatic logic signed [11:0] to_disp(input logic signed [11:0] raw, input int sh);
      logic signed [21:0] p;
      p = 22'(raw) * 22'sd1000;
      return 12'(p >>> sh);
   endfunction : to_disp

   function automatic logic [9:0] clamp_mon(input logic [9:0] raw);
      return (raw > MON_LIM) ? MON_LIM : raw;
   endfunction : clamp_mon

   ////////////////////////////////////////////////////////////////////////////////
   // combinational view of the synchronised inputs

   aisr_state_s        s_q;
   aisr_state_s        s_d;
   logic signed [3:0][11:0] gp_val;
   logic signed [11:0] term_val;
   logic signed [11:0] enc_val;
   logic signed [11:0] spd_val;
   logic               loop_low;
   logic signed [11:0] sc_value;
   logic        [10:0] sc_set;
   logic signed [11:0] sc_result;
   logic               tick;
   logic               drst_edge;
   logic        [10:0] off;
   logic               wr_ok;

   always_comb begin
      for (int i = 0; i < 4; i++) begin
         gp_val[i] = to_disp(12'($signed(s_q.sy2.gp_raw[i])), RAW_SHIFT_GP);
      end
   end

   aisr_loop u_loop (
      .raw      ($signed(s_q.sy2.spd_raw)),
      .cur_sel  (s_q.cur_sel),
      .loop_inv (s_q.loop_inv),
      .loop_ofs (s_q.loop_ofs),
      .value    (term_val),
      .loop_low (loop_low)
   );

   // encoder rate has its own scale ahead of the shared one
   aisr_scale u_enc_scale (
      .value   ($signed(s_q.sy2.enc_rate)),
      .setting (s_q.cfg[CFG_ENC]),
      .result  (enc_val)
   );

   assign spd_val = s_q.enc_sel ? enc_val : term_val;

   ////////////////////////////////////////////////////////////////////////////////
   // one shared multiplier serves every channel in turn, trading speed for area

   always_comb begin
      sc_value = 12'sh000;
      sc_set   = 11'h000;
      if (s_q.st == SEQ_ROUTE) begin
         if (s_q.ch < 3'(4)) begin
            sc_value = gp_val[s_q.ch[1:0]];
            sc_set   = s_q.cfg[CFG_SCL + int'(s_q.ch)];
         end else begin
            sc_value = spd_val;
            sc_set   = s_q.cfg[CFG_SCL + 4];
         end
      end else if (s_q.st == SEQ_LOAD) begin
         sc_value = param_exists(s_q.src_idx) ? src_value : 12'sh000;
         sc_set   = s_q.cfg[CFG_DSCL + int'(s_q.ch)];
      end
   end

   aisr_scale u_scale (
      .value   (sc_value),
      .setting (sc_set),
      .result  (sc_result)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      s_d        = s_q;
      s_d.sy1    = pins;
      s_d.sy2    = s_q.sy1;
      s_d.drst_old = s_q.sy2.drive_reset;
      drst_edge  = s_q.sy2.drive_reset && !s_q.drst_old;
      tick       = (s_q.div == 16'(SCAN_DIV - 1));
      s_d.div    = tick ? 16'h0000 : s_q.div + 16'h0001;
      s_d.route.valid = 1'b0;
      off        = par_req.sel - IDX_CFG_FIRST;
      wr_ok      = par_req.wr && !par_req.wdata[11] && (11'(par_req.wdata) <= SET_MAX);

      // parameter writes; monitors are read-only and ignore writes
      if (par_req.wr) begin
         if (par_req.sel >= IDX_CFG_FIRST && par_req.sel <= IDX_CFG_LAST && wr_ok) begin
            s_d.cfg[off[4:0]] = 11'(par_req.wdata);
         end
         if (par_req.wdata == 12'sh000 || par_req.wdata == 12'sh001) begin
            unique case (par_req.sel)
               IDX_ENC_SEL:  s_d.enc_sel  = par_req.wdata[0];
               IDX_CUR_SEL:  s_d.cur_sel  = par_req.wdata[0];
               IDX_LOOP_INV: s_d.loop_inv = par_req.wdata[0];
               IDX_LOOP_OFS: s_d.loop_ofs = par_req.wdata[0];
               default: ;
            endcase
         end
      end

      // parameter reads
      s_d.hit   = 1'b1;
      s_d.rdata = 12'h000;
      if (par_req.sel >= IDX_GP_FIRST && par_req.sel < IDX_SPEED_IN) begin
         s_d.rdata = gp_val[2'(par_req.sel - IDX_GP_FIRST)];
      end else if (par_req.sel == IDX_SPEED_IN) begin
         s_d.rdata = spd_val;
      end else if (par_req.sel == IDX_LINE_V) begin
         s_d.rdata = {2'b00, clamp_mon(s_q.sy2.line_raw)};
      end else if (par_req.sel == IDX_HEAT_T) begin
         s_d.rdata = {2'b00, clamp_mon(s_q.sy2.heat_raw)};
      end else if (par_req.sel >= IDX_CFG_FIRST && par_req.sel <= IDX_CFG_LAST) begin
         s_d.rdata = {1'b0, s_q.cfg[off[4:0]]};
      end else if (par_req.sel == IDX_ENC_SEL) begin
         s_d.rdata = {11'h000, s_q.enc_sel};
      end else if (par_req.sel == IDX_CUR_SEL) begin
         s_d.rdata = {11'h000, s_q.cur_sel};
      end else if (par_req.sel == IDX_LOOP_INV) begin
         s_d.rdata = {11'h000, s_q.loop_inv};
      end else if (par_req.sel == IDX_LOOP_OFS) begin
         s_d.rdata = {11'h000, s_q.loop_ofs};
      end else begin
         s_d.hit   = 1'b0;
      end

      // routing is latched only on a drive reset, so an edit cannot misroute mid-run
      if (drst_edge) begin
         for (int i = 0; i < NROUTE; i++) begin
            s_d.act_tgt[i] = s_q.cfg[CFG_TGT + i];
         end
      end

      // loop-open trip is sticky; a new low reading beats the clearing reset
      if (drst_edge) begin
         s_d.trip = 1'b0;
      end
      if (loop_low) begin
         s_d.trip = 1'b1;
      end

      // scan sequencer
      unique case (s_q.st)
         SEQ_IDLE: begin
            if (tick) begin
               s_d.st = SEQ_ROUTE;
               s_d.ch = 3'h0;
            end
         end
         SEQ_ROUTE: begin
            s_d.route.index = s_q.act_tgt[s_q.ch];
            s_d.route.value = sc_result;
            s_d.route.valid = param_exists(s_q.act_tgt[s_q.ch]);
            if (s_q.ch == 3'(NROUTE - 1)) begin
               s_d.st      = SEQ_FETCH;
               s_d.ch      = 3'h0;
               s_d.src_idx = s_q.cfg[CFG_SRC];
            end else begin
               s_d.ch = s_q.ch + 3'h1;
            end
         end
         SEQ_FETCH: begin
            s_d.st = SEQ_LOAD;                                  // source value settles
         end
         SEQ_LOAD: begin
            s_d.dac[s_q.ch] = sc_result;
            if (s_q.ch == 3'(NDAC - 1)) begin
               s_d.st = SEQ_IDLE;
            end else begin
               s_d.ch      = s_q.ch + 3'h1;
               s_d.src_idx = s_q.cfg[CFG_SRC + int'(s_q.ch) + 1];
               s_d.st      = SEQ_FETCH;
            end
         end
         default: begin
            s_d.st = SEQ_IDLE;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   // state register

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         s_q          <= '0;
         s_q.cfg      <= CFG_RST;
         for (int i = 0; i < NROUTE; i++) begin
            s_q.act_tgt[i] <= CFG_RST[CFG_TGT + i];
         end
         s_q.enc_sel  <= ENC_SEL_RST;
         s_q.cur_sel  <= CUR_SEL_RST;
         s_q.loop_inv <= LOOP_INV_RST;
         s_q.loop_ofs <= LOOP_OFS_RST;
         s_q.st       <= SEQ_IDLE;
      end else begin
         s_q <= s_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // outputs

   assign par_rdata = s_q.rdata;
   assign par_hit   = s_q.hit;
   assign route     = s_q.route;
   assign src_index = s_q.src_idx;
   assign dac_data  = s_q.dac;
   assign loop_trip = s_q.trip;

endmodule : aisr_top

/* File: sim/aisr_store.sv */
// parameter store model answering the output source fetches
module aisr_store (
   input  wire logic               clock,
   input  wire logic               reset,
   input  wire logic        [10:0] src_index,
   output logic signed      [11:0] src_value
);
   timeunit 1ns;
   timeprecision 100ps;
   import aisr_pkg::*;

   logic junk_q;

   // no kinder than the real store: unknown codes return a moving pattern
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         junk_q    <= 1'b0;
         src_value <= 12'sh000;
      end else begin
         junk_q <= ~junk_q;
         if (src_index / 100 >= MENU_FIRST && src_index / 100 <= MENU_LAST &&
             src_index % 100 >= PAR_FIRST && src_index % 100 <= PAR_LAST) begin
            src_value <= $signed({1'b0, src_index});
         end else begin
            src_value <= junk_q ? 12'sh5A5 : 12'shA5A;
         end
      end
   end
endmodule : aisr_store

/* File: sim/aisr_top_assertions.sv */
// port assertions for the analog scaling and routing block
module aisr_chk #(
   parameter int SCAN_DIV = 40
) (
   input wire logic                      clock,
   input wire logic                      reset,
   input wire aisr_pkg::aisr_pins_s      pins,
   input wire aisr_pkg::aisr_par_req_s   par_req,
   input wire logic               [11:0] par_rdata,
   input wire logic                      par_hit,
   input wire aisr_pkg::aisr_route_s     route,
   input wire logic               [10:0] src_index,
   input wire logic signed        [11:0] src_value,
   input wire logic signed   [2:0][11:0] dac_data,
   input wire logic                      loop_trip
);
   timeunit 1ns;
   timeprecision 100ps;
   import aisr_pkg::*;

   default clocking @(posedge clock); endclocking
   default disable iff (reset);

   function automatic logic in_lim(input logic signed [11:0] x);
      return x >= -VAL_LIM && x <= VAL_LIM;
   endfunction : in_lim

   function automatic logic code_ok(input logic [10:0] c);
      return c / 100 >= MENU_FIRST && c / 100 <= MENU_LAST && c % 100 >= PAR_FIRST && c % 100 <= PAR_LAST;
   endfunction : code_ok

   function automatic logic is_cfg(input logic [10:0] c);
      return c >= IDX_CFG_FIRST && c <= IDX_CFG_LAST;
   endfunction : is_cfg

   ////////////////////////////////////////
   // cycles since drive reset was last seen high; sync delay needs a margin
   logic [2:0] dr_low_q;
   logic [2:0] dr_low_d;
   always_comb begin
      dr_low_d = dr_low_q;
      if (pins.drive_reset) begin
         dr_low_d = 3'h0;
      end else if (dr_low_q != 3'h7) begin
         dr_low_d = dr_low_q + 3'h1;
      end
   end
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         dr_low_q <= 3'h0;
      end else begin
         dr_low_q <= dr_low_d;
      end
   end

   ////////////////////////////////////////
   sequence s_probe;
      !par_req.wr && is_cfg(par_req.sel);
   endsequence
   sequence s_good_write;
      par_req.wr && is_cfg(par_req.sel) && $unsigned(par_req.wdata) <= 12'h7CF;
   endsequence
   sequence s_bad_write;
      par_req.wr && par_req.sel == $past(par_req.sel) && $unsigned(par_req.wdata) > 12'h7CF;
   endsequence
   sequence s_same_read;
      !par_req.wr && par_req.sel == $past(par_req.sel);
   endsequence

   set_echo_a: assert property (s_good_write ##1 s_same_read |=> par_rdata == $past(par_req.wdata, 2))
      else $error("accepted setting not read back");
   set_refuse_a: assert property (s_probe ##1 s_bad_write ##1 s_same_read |=> par_rdata == $past(par_rdata, 2))
      else $error("out of range setting was taken");
   route_range_a: assert property (route.valid |-> in_lim(route.value))
      else $error("routed value beyond limit");
   dac_range_a: assert property (in_lim(dac_data[0]) && in_lim(dac_data[1]) && in_lim(dac_data[2]))
      else $error("output value beyond limit");
   route_target_a: assert property (route.valid |-> code_ok(route.index))
      else $error("route to a code naming no parameter");
   unknown_read_a: assert property (!(par_req.sel >= IDX_GP_FIRST && par_req.sel <= IDX_LOOP_OFS)
      |=> !par_hit && par_rdata == 12'h000)
      else $error("unknown code answered");
   known_read_a: assert property (par_req.sel >= IDX_GP_FIRST && par_req.sel <= IDX_LOOP_OFS |=> par_hit)
      else $error("known code not answered");
   input_range_a: assert property (par_req.sel >= IDX_GP_FIRST && par_req.sel <= IDX_SPEED_IN
      |=> in_lim(par_rdata))
      else $error("input display beyond limit");
   monitor_range_a: assert property (par_req.sel == IDX_LINE_V || par_req.sel == IDX_HEAT_T
      |=> par_rdata <= 12'h3E8)
      else $error("monitor beyond limit");
   trip_sticky_a: assert property (loop_trip && dr_low_q == 3'h7 |=> loop_trip)
      else $error("loop trip dropped without drive reset");
endmodule : aisr_chk

bind aisr_top aisr_chk #(.SCAN_DIV(SCAN_DIV)) aisr_chk_i (
   .clock(clock), .reset(reset), .pins(pins), .par_req(par_req), .par_rdata(par_rdata),
   .par_hit(par_hit), .route(route), .src_index(src_index), .src_value(src_value),
   .dac_data(dac_data), .loop_trip(loop_trip));

/* File: sim/aisr_top_tb.sv */
// self-checking testbench for the analog scaling and routing block
module aisr_top_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import aisr_pkg::*;

   logic                    clock;
   logic                    reset;
   aisr_pins_s              pins;
   aisr_par_req_s           par_req;
   logic             [11:0] par_rdata;
   logic                    par_hit;
   aisr_route_s             route;
   logic             [10:0] src_index;
   logic signed      [11:0] src_value;
   logic signed [2:0][11:0] dac_data;
   logic                    loop_trip;
   logic             [11:0] v;
   int                      n_errors;
   int                      check_count;

   // short scan period keeps the run brief
   aisr_top #(.SCAN_DIV(8)) aisr_top_i (.clock(clock), .reset(reset), .pins(pins), .par_req(par_req),
      .par_rdata(par_rdata), .par_hit(par_hit), .route(route), .src_index(src_index),
      .src_value(src_value), .dac_data(dac_data), .loop_trip(loop_trip));
   aisr_store aisr_store_i (.clock(clock), .reset(reset), .src_index(src_index), .src_value(src_value));

   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end

   ////////////////////////////////////////
   task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected at %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // ends at a falling edge so outputs are settled
   task automatic settle;
      repeat (40) @(posedge clock);
      @(negedge clock);
   endtask : settle

   task automatic rd(input logic [10:0] sel, output logic [11:0] val);
      @(posedge clock);
      par_req.sel <= sel;
      @(posedge clock);
      @(negedge clock);
      val = par_rdata;
   endtask : rd

   task automatic wr(input logic [10:0] sel, input logic [11:0] data);
      @(posedge clock);
      par_req.sel   <= sel;
      par_req.wr    <= 1'b1;
      par_req.wdata <= data;
      @(posedge clock);
      par_req.wr <= 1'b0;
   endtask : wr

   task automatic drive_reset_pulse;
      @(posedge clock);
      pins.drive_reset <= 1'b1;
      repeat (4) @(posedge clock);
      pins.drive_reset <= 1'b0;
      settle();
   endtask : drive_reset_pulse

   // routes repeat every scan, so a window of several scans is enough
   task automatic wait_route(input logic [10:0] idx, input logic [11:0] exp, input logic present);
      logic seen;
      seen = 1'b0;
      for (int i = 0; i < 60 && !seen; i++) begin
         @(negedge clock);
         if (route.valid === 1'b1 && route.index === idx) begin
            seen = 1'b1;
            chk(route.value, exp);
         end
      end
      chk({11'h000, seen}, {11'h000, present});
   endtask : wait_route

   ////////////////////////////////////////
   task automatic t_defaults;
      logic [11:0] dflt [17] = '{12'h0C9, 12'h12E, 12'h130, 12'h13E, 12'h077, 12'h078, 12'h198, 12'h075,
         12'h3E8, 12'h3E8, 12'h3E8, 12'h3E8, 12'h3E8, 12'h3E8, 12'h3E8, 12'h3E8, 12'h1A3};
      for (int i = 0; i < 17; i++) begin
         rd(IDX_CFG_FIRST + 11'(i), v);
         chk(v, dflt[i]);
      end
      rd(11'h2BC, v);
      chk({v[11:1], par_hit}, 12'h000);
      rd(11'h2CC, v);
      wr(11'h2CC, 12'h7D0);
      rd(11'h2CC, v);
      chk(v, 12'h3E8);
      wr(IDX_GP_FIRST, 12'h005);
      rd(IDX_GP_FIRST, v);
      chk(v, 12'h000);
      $display("defaults done");
   endtask : t_defaults

   task automatic t_dac;
      settle();
      chk(dac_data[0], 12'h0C9);
      chk(dac_data[1], 12'h12E);
      chk(dac_data[2], 12'h130);
      wr(11'h2D1, 12'h7CF);
      wr(11'h2C5, 12'h130);
      wr(11'h2D2, 12'h1F4);
      wr(11'h2C6, 12'h000);
      settle();
      chk(dac_data[0], 12'h191);
      chk(dac_data[1], 12'h098);
      chk(dac_data[2], 12'h000);
      $display("output sourcing done");
   endtask : t_dac

   task automatic t_gp;
      @(posedge clock);
      pins.gp_raw <= {10'h064, 10'h300, 10'h1FF, 10'h200};
      wr(11'h2CC, 12'h001);
      wr(11'h2CD, 12'h7CF);
      wr(11'h2CE, 12'h7CF);
      wr(11'h2CF, 12'h000);
      settle();
      rd(IDX_GP_FIRST, v);
      chk(v, 12'hC18);
      rd(IDX_GP_FIRST + 11'h001, v);
      chk(v, 12'h3E6);
      wait_route(11'h13E, 12'hFFF, 1'b1);
      wait_route(11'h077, 12'h3E8, 1'b1);
      wait_route(11'h078, 12'hC19, 1'b1);
      wait_route(11'h198, 12'h000, 1'b1);
      $display("input scaling done");
   endtask : t_gp

   task automatic t_speed;
      @(posedge clock);
      pins.spd_raw  <= 12'h400;
      pins.enc_rate <= 12'h3E8;
      wr(11'h2D0, 12'h5DC);
      settle();
      rd(IDX_SPEED_IN, v);
      chk(v, 12'h1F4);
      wait_route(11'h075, 12'h2EE, 1'b1);
      wr(IDX_ENC_SEL, 12'h001);
      settle();
      rd(IDX_SPEED_IN, v);
      chk(v, 12'h1A3);
      wait_route(11'h075, 12'h274, 1'b1);
      wr(IDX_ENC_SEL, 12'h000);
      wr(11'h2D0, 12'h3E8);
      $display("speed reference done");
   endtask : t_speed

   task automatic t_route;
      wr(11'h2C7, 12'h1F5);
      wr(11'h2C8, 12'h7CF);
      wr(11'h2CB, 12'h12D);
      settle();
      wait_route(11'h13E, 12'hFFF, 1'b1);
      drive_reset_pulse();
      wait_route(11'h1F5, 12'hFFF, 1'b1);
      wait_route(11'h12D, 12'h1F4, 1'b1);
      wait_route(11'h7CF, 12'h000, 1'b0);
      $display("routing done");
   endtask : t_route

   task automatic t_loop;
      @(posedge clock);
      pins.spd_raw <= 12'h4CD;
      wr(IDX_CUR_SEL, 12'h001);
      settle();
      rd(IDX_SPEED_IN, v);
      chk(v, 12'h1F3);
      wr(IDX_LOOP_INV, 12'h001);
      settle();
      rd(IDX_SPEED_IN, v);
      chk(v, 12'h1F5);
      // offset off first, or the low reading would trip on the way
      wr(IDX_LOOP_OFS, 12'h000);
      @(posedge clock);
      pins.spd_raw <= 12'h000;
      settle();
      rd(IDX_SPEED_IN, v);
      chk(v, 12'h3E8);
      wr(IDX_LOOP_INV, 12'h000);
      settle();
      rd(IDX_SPEED_IN, v);
      chk(v, 12'h000);
      chk({11'h000, loop_trip}, 12'h000);
      wr(IDX_LOOP_OFS, 12'h001);
      settle();
      chk({11'h000, loop_trip}, 12'h001);
      @(posedge clock);
      pins.spd_raw <= 12'h4CD;
      settle();
      chk({11'h000, loop_trip}, 12'h001);
      drive_reset_pulse();
      chk({11'h000, loop_trip}, 12'h000);
      wr(IDX_CUR_SEL, 12'h000);
      $display("current loop done");
   endtask : t_loop

   task automatic t_monitor;
      @(posedge clock);
      pins.line_raw <= 10'h258;
      pins.heat_raw <= 10'h019;
      settle();
      rd(IDX_LINE_V, v);
      chk(v, 12'h258);
      rd(IDX_HEAT_T, v);
      chk(v, 12'h019);
      wr(IDX_LINE_V, 12'h005);
      rd(IDX_LINE_V, v);
      chk(v, 12'h258);
      $display("monitors done");
   endtask : t_monitor

   ////////////////////////////////////////
   task automatic conclude;
      $display("comparisons %0d, mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : conclude

   initial begin
      repeat (20000) @(posedge clock);
      n_errors++;
      $display("watchdog expired");
      conclude();
   end

   initial begin
      reset       = 1'b1;
      pins        = '0;
      par_req     = '0;
      n_errors    = 0;
      check_count = 0;
      repeat (5) @(posedge clock);
      reset <= 1'b0;
      t_defaults();
      t_dac();
      t_gp();
      t_speed();
      t_route();
      t_loop();
      t_monitor();
      conclude();
   end
endmodule : aisr_top_tb
